// >>> common/modem_hs_pkg.sv
// shared constants and handshake-line types for the modem handshake block
// ==========================================================================
// How it works
// - Receive takes data only while carrier detect is on, from its rise.
// - Transmit data goes out only while all four handshake lines are on.
// - A dropped request stays off until clear-to-send has been seen off.
// - Equipment ready is on while the block can send and receive, else off.
// - Request-to-send is on while data waits to be sent and equipment ready is on, else off.
package modem_hs_pkg;
  // ========================================================================
  // line levels
  localparam logic LINE_MARK = 1'b1;
  localparam logic LINE_SPACE = 1'b0;
  // ========================================================================
  // widths and timing
  localparam int DATA_W = 8;
  localparam int SYNC_STAGES = 3;
  localparam int BUF_DEPTH = 2;
  localparam int CLK_HZ = 20000000;
  localparam int BAUD_DEFAULT = 9600;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_DEFAULT;
  localparam int STOP_BITS = 1;
  localparam int BIT_CNT_W = 16;
  localparam int IDX_W = 4;

  typedef struct packed {
    logic carrier;
    logic clearSend;
    logic remoteReady;
  } hs_in_t;

  typedef struct packed {
    logic requestSend;
    logic equipmentReady;
  } hs_out_t;
endpackage : modem_hs_pkg

// >>> core/two_entry_buffer.sv
// two-entry valid/ready buffer for transmit words
`timescale 1ns/10ps
module two_entry_buffer
  import modem_hs_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] slot0_reg;
  logic [WIDTH-1:0] slot1_reg;
  logic [1:0] count_reg;
  wire pushW = inValid && inReady && clkEn;
  wire popW = outValid && outReady && clkEn;

  assign inReady = (count_reg != 2'h2);
  assign outValid = (count_reg != 2'h0);
  assign outData = slot0_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_reg <= 2'h0;
      slot0_reg <= '0;
      slot1_reg <= '0;
    end else begin
      // head moves forward on pop; push fills next free slot
      if (popW) begin
        slot0_reg <= slot1_reg;
      end
      if (pushW) begin
        if (count_reg == 2'h0 || (count_reg == 2'h1 && popW)) begin
          slot0_reg <= inData;
        end else begin
          slot1_reg <= inData;
        end
      end
      count_reg <= count_reg + {1'b0, pushW} - {1'b0, popW};
    end
  end
endmodule : two_entry_buffer

// >>> core/serial_modem_handshake.sv
// modem-control handshake with simple async transmitter and receiver
`timescale 1ns/10ps
module serial_modem_handshake
  import modem_hs_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic moduleReady,
  input wire logic txValid,
  output logic txReady,
  input wire logic [DATA_W-1:0] txData,
  output logic rxValid,
  output logic [DATA_W-1:0] rxData,
  output logic tx_line,
  input wire logic rxLine,
  input wire logic carrier_detect_in,
  input wire logic clearSendIn,
  input wire logic remote_ready_in,
  output logic request_send_out,
  output logic equipment_ready_out,
  output logic txActive,
  output logic rxActive
);
  // ========================================================================
  // pin synchronisers: three stages, change taken when 2nd and 3rd agree
  localparam int NIN = 4;
  logic [NIN-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
  wire [NIN-1:0] pinsW = {rxLine, carrier_detect_in, clearSendIn,
    remote_ready_in};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
      filt_reg <= '1;
    end else if (clkEn) begin
      s1_reg <= pinsW;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < NIN; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          filt_reg[i] <= s3_reg[i];
        end
      end
    end
  end
  // space (zero) means on
  hs_in_t hsIn;
  assign hsIn.carrier = (filt_reg[2] == LINE_SPACE);
  assign hsIn.clearSend = (filt_reg[1] == LINE_SPACE);
  assign hsIn.remoteReady = (filt_reg[0] == LINE_SPACE);
  wire rxBitW = filt_reg[3];

  // ========================================================================
  // transmit buffer
  logic bufValid;
  logic bufReady;
  logic [DATA_W-1:0] bufData;
  two_entry_buffer #(.WIDTH(DATA_W)) txBuf (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .inValid(txValid),
    .inReady(txReady),
    .inData(txData),
    .outValid(bufValid),
    .outReady(bufReady),
    .outData(bufData)
  );

  // ========================================================================
  // handshake outputs
  hs_out_t hs_reg;
  logic waitClear_reg;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;
  tx_state_t txState_reg;
  wire pendingW = bufValid || (txState_reg == TX_SHIFT);
  wire rsWantW = pendingW && hs_reg.equipmentReady;
  // a dropped request may not return before clear-to-send was seen off
  wire rsAllowW = !waitClear_reg || !hsIn.clearSend;
  wire allOnW = hs_reg.requestSend && hs_reg.equipmentReady
    && hsIn.clearSend && hsIn.remoteReady;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hs_reg <= '0;
      waitClear_reg <= 1'b0;
    end else if (clkEn) begin
      // ready follows moduleReady a cycle late, with no hold-off
      hs_reg.equipmentReady <= moduleReady;
      if (hs_reg.requestSend && !rsWantW) begin
        hs_reg.requestSend <= 1'b0;
        waitClear_reg <= 1'b1;
      end else if (!hs_reg.requestSend) begin
        if (!hsIn.clearSend) begin
          waitClear_reg <= 1'b0;
        end
        hs_reg.requestSend <= rsWantW && rsAllowW;
      end
    end
  end
  assign request_send_out = hs_reg.requestSend ? LINE_SPACE : LINE_MARK;
  assign equipment_ready_out =
    hs_reg.equipmentReady ? LINE_SPACE : LINE_MARK;

  // ========================================================================
  // transmitter: frame starts only with all four lines on
  logic [BIT_CNT_W-1:0] txCnt_reg;
  logic [IDX_W-1:0] txIdx_reg;
  logic [DATA_W+1:0] txShift_reg;
  logic txLine_reg;
  wire txTickW = (txCnt_reg == BIT_CNT_W'(BIT_CYC - 1));
  wire txLastW = (txIdx_reg == IDX_W'(DATA_W + 1 + STOP_BITS - 1));
  assign bufReady = (txState_reg == TX_IDLE) && allOnW;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txState_reg <= TX_IDLE;
      txCnt_reg <= '0;
      txIdx_reg <= '0;
      txShift_reg <= '1;
      txLine_reg <= LINE_MARK;
    end else if (clkEn) begin
      case (txState_reg)
        TX_IDLE: begin
          txLine_reg <= LINE_MARK;
          if (bufValid && bufReady) begin
            txShift_reg <= {LINE_MARK, bufData, LINE_SPACE};
            txCnt_reg <= '0;
            txIdx_reg <= '0;
            txState_reg <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          // a line dropping cuts the frame; the word is lost, not resent
          if (!allOnW) begin
            txLine_reg <= LINE_MARK;
            txState_reg <= TX_IDLE;
          end else begin
            txLine_reg <= txShift_reg[0];
            txCnt_reg <= txTickW ? '0 : txCnt_reg + 1'b1;
            if (txTickW) begin
              txShift_reg <= {LINE_MARK, txShift_reg[DATA_W+1:1]};
              txIdx_reg <= txIdx_reg + 1'b1;
              if (txLastW) begin
                txState_reg <= TX_IDLE;
              end
            end
          end
        end
        default: txState_reg <= TX_IDLE;
      endcase
    end
  end
  assign tx_line = txLine_reg;
  assign txActive = (txState_reg == TX_SHIFT);

  // ========================================================================
  // receiver: gated on carrier, mark seen as idle
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_t;
  rx_state_t rxState_reg;
  logic [BIT_CNT_W-1:0] rxCnt_reg;
  logic [IDX_W-1:0] rxIdx_reg;
  logic [DATA_W-1:0] rxShift_reg;
  logic rxValid_reg;
  logic [DATA_W-1:0] rxData_reg;
  wire rxTickW = (rxCnt_reg == BIT_CNT_W'(BIT_CYC - 1));
  wire rxHalfW = (rxCnt_reg == BIT_CNT_W'(BIT_CYC / 2 - 1));
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxState_reg <= RX_IDLE;
      rxCnt_reg <= '0;
      rxIdx_reg <= '0;
      rxShift_reg <= '0;
      rxValid_reg <= 1'b0;
      rxData_reg <= '0;
    end else if (clkEn) begin
      rxValid_reg <= 1'b0;
      if (!hsIn.carrier) begin
        // carrier loss abandons any partial word
        rxState_reg <= RX_IDLE;
      end else begin
        case (rxState_reg)
          RX_IDLE: begin
            rxCnt_reg <= '0;
            if (rxBitW == LINE_SPACE) begin
              rxState_reg <= RX_START;
            end
          end
          RX_START: begin
            // recheck at half bit so a short dip is not taken as a start
            rxCnt_reg <= rxCnt_reg + 1'b1;
            if (rxHalfW) begin
              rxCnt_reg <= '0;
              rxIdx_reg <= '0;
              rxState_reg <= (rxBitW == LINE_SPACE) ? RX_DATA : RX_IDLE;
            end
          end
          RX_DATA: begin
            rxCnt_reg <= rxTickW ? '0 : rxCnt_reg + 1'b1;
            if (rxTickW) begin
              rxIdx_reg <= rxIdx_reg + 1'b1;
              if (rxIdx_reg == IDX_W'(DATA_W)) begin
                // stop bit must be mark, else word dropped
                if (rxBitW == LINE_MARK) begin
                  rxData_reg <= rxShift_reg;
                  rxValid_reg <= 1'b1;
                end
                rxState_reg <= RX_IDLE;
              end else begin
                rxShift_reg <= {rxBitW, rxShift_reg[DATA_W-1:1]};
              end
            end
          end
          default: rxState_reg <= RX_IDLE;
        endcase
      end
    end
  end
  assign rxValid = rxValid_reg;
  assign rxData = rxData_reg;
  assign rxActive = (rxState_reg != RX_IDLE);
endmodule : serial_modem_handshake

// >>> sim/modem_hs_chk.sv
// concurrent checks on the modem handshake block ports
`timescale 1ns/10ps
module modem_hs_chk
  import modem_hs_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic moduleReady,
  input wire logic rxValid,
  input wire logic tx_line,
  input wire logic carrier_detect_in,
  input wire logic clearSendIn,
  input wire logic request_send_out,
  input wire logic equipment_ready_out,
  input wire logic txActive,
  input wire logic rxActive
);
  logic armed;
  logic [3:0] offCnt;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst || !clkEn);
  // ========================================================================
  // helpers: re-request guard, carrier-off age
  always_ff @(posedge clk) begin
    if (sys_rst || clearSendIn == LINE_MARK) armed <= 1'b0;
    else if ($rose(request_send_out)) armed <= 1'b1;
    if (sys_rst || carrier_detect_in == LINE_SPACE) offCnt <= 4'h0;
    else if (offCnt != 4'hF) offCnt <= offCnt + 4'h1;
  end
  sequence startBit;
    tx_line == LINE_SPACE [*8];
  endsequence
  reset_idle_a: assert property (
    $fell(sys_rst) |-> tx_line && request_send_out && equipment_ready_out)
    else $error("outputs not idle after reset");
  send_gate_a: assert property (
    $rose(txActive) |->
      !$past(request_send_out) && !$past(equipment_ready_out))
    else $error("frame began without handshake");
  start_bit_a: assert property (
    $rose(txActive) |-> ##[0:1] startBit) else $error("start bit not space");
  rerequest_hold_a: assert property (
    armed |-> request_send_out) else $error("request again before clear off");
  ready_drop_a: assert property (
    !moduleReady |=> equipment_ready_out) else $error("ready stayed on");
  ready_rise_a: assert property (
    $rose(moduleReady) |=> !equipment_ready_out) else $error("ready not on");
  request_er_a: assert property (
    $fell(request_send_out) |-> !$past(equipment_ready_out))
    else $error("request without ready");
  line_gate_a: assert property (
    equipment_ready_out && $past(equipment_ready_out) |-> tx_line)
    else $error("data sent without equipment ready");
  carrier_gate_a: assert property (
    offCnt == 4'hF |-> !rxValid && !rxActive)
    else $error("receive with carrier off");
endmodule : modem_hs_chk

bind serial_modem_handshake modem_hs_chk chk (
  .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
  .moduleReady(moduleReady),
  .rxValid(rxValid), .tx_line(tx_line),
  .carrier_detect_in(carrier_detect_in), .clearSendIn(clearSendIn),
  .request_send_out(request_send_out),
  .equipment_ready_out(equipment_ready_out),
  .txActive(txActive), .rxActive(rxActive));

// >>> sim/remote_station.sv
// remote station model: handshake replies, frame sender and catcher
`timescale 1ns/10ps
module remote_station
  import modem_hs_pkg::*;
#(
  parameter int BIT_CYC = 16
) (
  input wire logic clk,
  input wire logic txLine,
  input wire logic rsOut,
  input wire logic erOut,
  input wire logic carrierOn,
  input wire logic csAllow,
  input wire logic csStuck,
  output logic rxLine,
  output logic carrier,
  output logic clearSend,
  output logic remoteReady
);
  logic [DATA_W-1:0] got[$];
  logic [DATA_W-1:0] b;
  logic rxBit = LINE_MARK;
  initial clearSend = LINE_MARK;
  assign carrier = carrierOn ? LINE_SPACE : LINE_MARK;
  assign rxLine = carrierOn ? rxBit : LINE_MARK;
  assign remoteReady = erOut;
  // csStuck is a commanded fault: clear held on regardless of request
  always @(posedge clk)
    clearSend <= (csStuck || (!rsOut && csAllow)) ?
      LINE_SPACE : LINE_MARK;
  task automatic sendByte(input logic [DATA_W-1:0] d);
    logic [DATA_W+1:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < DATA_W + 2; i++) begin
      rxBit = f[i];
      repeat (BIT_CYC) @(posedge clk);
      #1;
    end
  endtask : sendByte
  initial forever begin
    @(negedge txLine);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < DATA_W; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      b[i] = txLine;
    end
    repeat (BIT_CYC) @(posedge clk);
    got.push_back(b);
  end
endmodule : remote_station

// >>> sim/tb_top.sv
// self-checking bench for the modem handshake block
`timescale 1ns/10ps
module tb_top
  import modem_hs_pkg::*;
;
  logic clk = 1'b0, sysRst = 1'b1, moduleReady = 1'b0, txValid = 1'b0;
  logic carrierOn = 1'b0, csAllow = 1'b0, csStuck = 1'b0, clkEn = 1'b1;
  logic [DATA_W-1:0] txData = 8'h00, rxData, rxd;
  logic txReady, rxValid, txLine, rxLine, cd, cs, dr, rs, er;
  int miscompares = 0, checksDone = 0;
  serial_modem_handshake #(.BIT_CYC(16)) DUT (.clk(clk), .sys_rst(sysRst),
    .clkEn(clkEn), .moduleReady(moduleReady), .txValid(txValid),
    .txReady(txReady), .txData(txData), .rxValid(rxValid), .rxData(rxData),
    .tx_line(txLine), .rxLine(rxLine), .carrier_detect_in(cd),
    .clearSendIn(cs), .remote_ready_in(dr), .request_send_out(rs),
    .equipment_ready_out(er), .txActive(), .rxActive());
  remote_station #(.BIT_CYC(16)) stn (.clk(clk), .txLine(txLine),
    .rsOut(rs), .erOut(er), .carrierOn(carrierOn), .csAllow(csAllow),
    .csStuck(csStuck), .rxLine(rxLine), .carrier(cd), .clearSend(cs),
    .remoteReady(dr));
  initial forever #25 clk = ~clk;
  // ========================================================================
  // bench tasks
  function automatic logic [7:0] st();
    return {4'h0, txReady, rs, er, txLine};
  endfunction : st
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // leaves valid high so back-to-back words need no gap
  task push(input logic [DATA_W-1:0] d);
    int i;
    i = 0;
    txValid = 1'b1;
    txData = d;
    while (txReady !== 1'b1 && i < 2000) begin
      cyc(1);
      i++;
    end
    if (i == 2000) miscompares++;
    cyc(1);
  endtask : push
  task waitGot(input int n);
    int i;
    i = 0;
    while (stn.got.size() < n && i < 3000) begin
      cyc(1);
      i++;
    end
    if (i == 3000) miscompares++;
  endtask : waitGot
  task recv;
    int i;
    i = 0;
    while (rxValid !== 1'b1 && i < 400) begin
      cyc(1);
      i++;
    end
    if (i == 400) miscompares++;
    rxd = rxData;
  endtask : recv
  task give_verdict;
    $display("checks %0d, mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  initial begin
    #2000000;
    miscompares++;
    give_verdict();
  end
  initial begin
    cyc(6);
    sysRst = 1'b0;
    cyc(1);
    chk(st(), 8'h0F);
    moduleReady = 1'b1;
    cyc(2);
    chk(st(), 8'h0D);
    push(8'h5A);
    push(8'hC3);
    txValid = 1'b0;
    cyc(6);
    chk(st(), 8'h01);
    csAllow = 1'b1;
    push(8'h81);
    txValid = 1'b0;
    waitGot(3);
    csStuck = 1'b1;
    chk(stn.got[0], 8'h5A);
    chk(stn.got[1], 8'hC3);
    chk(stn.got[2], 8'h81);
    // let the last frame end so request drops under a stuck clear
    cyc(20);
    chk(st(), 8'h0D);
    push(8'h24);
    txValid = 1'b0;
    cyc(60);
    chk(st(), 8'h0D);
    csStuck = 1'b0;
    waitGot(4);
    chk(stn.got[3], 8'h24);
    carrierOn = 1'b1;
    cyc(8);
    fork
      stn.sendByte(8'hA5);
      recv();
    join
    chk(rxd, 8'hA5);
    // all-space word: an uncut frame would show space at the check
    push(8'h00);
    txValid = 1'b0;
    cyc(40);
    moduleReady = 1'b0;
    carrierOn = 1'b0;
    cyc(30);
    chk(st(), 8'h0F);
    clkEn = 1'b0;
    moduleReady = 1'b1;
    cyc(10);
    chk(st(), 8'h0F);
    clkEn = 1'b1;
    cyc(2);
    chk(st(), 8'h0D);
    give_verdict();
  end
endmodule : tb_top
